// ### converter_status.sv
// Purpose: Status register of a sigma-delta converter with ready pin output.
// Assumes: Serial framing decoded elsewhere; strobes are one-cycle pulses.
// Notes: All outputs registered.
// Summary of operation
// R1: Read-only 8-bit status, address 0, reset 0x80.
// R2: Append status after data when option set.
// R3: Ready flag on data-out while selected, idle.
// R4: Ready goes low on new result write.
// R5: Calibration: low on calibration result write.
// R6: Data register read sets ready high.
// R7: Bit 6 flags overrange or underrange.
// R8: Clamp overrange to ones, underrange zeros.
// R9: Range flag updated only on result write.
// R10: Bit 5 set on failed write check.
// R11: Any status read clears write-check flag. The code keeps the flag when a failing write falls in the same cycle.
// R12: Host checks read CRC itself.
// R13: Bit 4 set when registers change while checking.
// R14: Integrity flag cleared only by disabling check.
// R15: Bits 3:0 give channel of held result.
// R16: Channel field is binary channel index.
// R17: Host reads status with select zero, read.
// R18: Mode register write sets ready high.
`timescale 1ns/1ps
`default_nettype none
module converter_status
  import conv_status_pkg::*;
(
  // Clock and reset.
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  // Conversion engine.
  input wire logic result_wr_i,
  input wire logic calib_mode_i,
  input wire logic calib_done_i,
  input wire logic [DATA_W-1:0] raw_result_i,
  input wire logic over_range_i,
  input wire logic under_range_i,
  input wire logic [3:0] result_channel_i,
  // Serial interface decoder.
  input wire logic cs_b_i,
  input wire logic reg_read_i,
  input wire logic [5:0] comms_register_select_i,
  input wire logic reg_write_i,
  input wire logic write_crc_fail_i,
  input wire logic append_status_i,
  input wire logic integrity_en_i,
  input wire logic [SNAP_W-1:0] reg_image_i,
  // Outputs.
  output logic [7:0] converter_status_o,
  output logic [DATA_W-1:0] data_reg_o,
  output logic append_byte_o,
  output logic dout_ready_o,
  output logic dout_oe_b_o
);
  // Flag and field registers behind the status byte.
  logic waiting;
  logic range_err;
  logic wrchk_err;
  logic integ_err;
  logic [3:0] channel;
  // Integrity bookkeeping: enable history and the registered compare.
  logic integ_en_q;
  logic differs;

  // One select compare serves every read and write decode, so the width lives in one place.
  function automatic logic select_hit(input logic [5:0] sel, input logic [5:0] addr);
    return sel == addr;
  endfunction : select_hit

  // Calibration results replace conversion results as the ready event.
  wire result_event = calib_mode_i ? calib_done_i : result_wr_i; // [R4] [R5]
  wire out_of_range = over_range_i || under_range_i;

  // Serial access decode; the select only means something while its strobe is high.
  wire status_rd = reg_read_i && select_hit(comms_register_select_i, STATUS_ADDR); // [R11]
  wire data_rd = reg_read_i && select_hit(comms_register_select_i, DATA_ADDR); // [R6]
  wire mode_wr = reg_write_i && select_hit(comms_register_select_i, MODE_ADDR); // [R18]
  wire crc_fault = reg_write_i && write_crc_fail_i; // [R10]

  // The snapshot is taken on the rising edge of the enable only.
  wire capture = integrity_en_i && !integ_en_q; // [R13]
  // The compare made while the enable was low is against a stale image, so it is
  // ignored until the enable has been seen for one cycle.
  wire differs_valid = differs && integ_en_q; // [R13]

  // Overrange wins when both limits are flagged, matching a saturated high result.
  wire [DATA_W-1:0] clamped = over_range_i ? DATA_ALL_ONES :
                              (under_range_i ? DATA_ALL_ZEROS : raw_result_i); // [R8]

  // New result wins over a simultaneous data read so the event is not lost.
  wire next_waiting = result_event ? 1'b0 : ((data_rd || mode_wr) ? 1'b1 : waiting); // [R4] [R6] [R18]
  wire next_range = result_wr_i ? out_of_range : range_err; // [R7] [R9]
  // A failing write in the same cycle as a status read keeps the flag, so the fault is not lost.
  wire next_wrchk = crc_fault ? 1'b1 : (status_rd ? 1'b0 : wrchk_err); // [R10] [R11]
  // Only dropping the enable clears the integrity flag; reads leave it alone.
  wire next_integ = !integrity_en_i ? 1'b0 : (differs_valid ? 1'b1 : integ_err); // [R13] [R14]
  wire [3:0] next_channel = result_wr_i ? result_channel_i : channel; // [R15] [R16]
  wire [7:0] next_status = {next_waiting, next_range, next_wrchk, next_integ, next_channel}; // [R1]
  // The pin carries ready only while selected and no register is being shifted out.
  wire next_oe_b = cs_b_i || reg_read_i; // [R3]

  integrity_snapshot u_snap (
    .ref_clk_i(ref_clk_i),
    .rst_b_i(rst_b_i),
    .capture_i(capture),
    .image_i(reg_image_i),
    .differs_o(differs)
  );

  // Status flags.
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      waiting <= STATUS_RESET[BIT_WAITING]; // [R1]
      range_err <= STATUS_RESET[BIT_RANGE];
      wrchk_err <= STATUS_RESET[BIT_WRCHK];
      integ_err <= STATUS_RESET[BIT_INTEG];
    end else begin
      waiting <= next_waiting;
      range_err <= next_range;
      wrchk_err <= next_wrchk;
      integ_err <= next_integ;
    end
  end

  // Held result and its channel; both change only when a result is written.
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      data_reg_o <= DATA_ALL_ZEROS;
      channel <= STATUS_RESET[3:0];
    end else if (result_wr_i) begin
      data_reg_o <= clamped; // [R8]
      channel <= next_channel; // [R15] [R16]
    end
  end

  // Enable history for the snapshot edge detector; its reset level matches an idle enable.
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      integ_en_q <= 1'b0;
    end else begin
      integ_en_q <= integrity_en_i;
    end
  end

  // Outputs are registered so the shared pin never sees decode glitches.
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      converter_status_o <= STATUS_RESET;
      append_byte_o <= 1'b0;
      dout_ready_o <= STATUS_RESET[BIT_WAITING];
      dout_oe_b_o <= 1'b1;
    end else begin
      converter_status_o <= next_status; // [R1]
      append_byte_o <= data_rd && append_status_i; // [R2]
      dout_ready_o <= next_waiting; // [R3]
      dout_oe_b_o <= next_oe_b; // [R3]
    end
  end

  // Ready flag and pin.
  a_ready_low_event: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // [R4]
    result_event |=> !converter_status_o[BIT_WAITING]) else $error("ready not low after result");
  a_ready_high_read: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // [R6]
    (data_rd && !result_event) |=> converter_status_o[BIT_WAITING]) else $error("ready not high after read");
  a_mode_write_ready: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // [R18]
    (mode_wr && !result_event) |=> dout_ready_o) else $error("mode write did not raise ready");
  a_calib_ignores: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // [R5]
    (calib_mode_i && !calib_done_i && !data_rd && !mode_wr) |=> $stable(waiting))
    else $error("ready moved in calibration without result");
  a_pin_drive: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // [R3]
    (!cs_b_i && !reg_read_i) |=> !dout_oe_b_o) else $error("pin not driven while idle");
  a_pin_release: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // [R3]
    (cs_b_i || reg_read_i) |=> dout_oe_b_o) else $error("pin driven while deselected or reading");

  // Range flag and held result.
  a_range_hold: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // [R9]
    !result_wr_i |=> $stable(range_err)) else $error("range flag changed without result");
  a_range_set: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // [R7]
    (result_wr_i && out_of_range) |=> converter_status_o[BIT_RANGE]) else $error("range flag not set");
  a_range_clear: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // [R9]
    (result_wr_i && !out_of_range) |=> !converter_status_o[BIT_RANGE]) else $error("range flag not cleared");
  a_clamp_over: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // [R8]
    (result_wr_i && over_range_i) |=> data_reg_o == DATA_ALL_ONES && range_err) else $error("overrange not clamped");
  a_clamp_under: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // [R8]
    (result_wr_i && under_range_i && !over_range_i) |=> data_reg_o == DATA_ALL_ZEROS && range_err)
    else $error("underrange not clamped");
  a_data_hold: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // [R8]
    !result_wr_i |=> $stable(data_reg_o)) else $error("data changed without result");

  // Write check flag.
  a_wrchk_set: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // [R10]
    (reg_write_i && write_crc_fail_i) |=> converter_status_o[BIT_WRCHK]) else $error("write check flag not set");
  a_wrchk_clear: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // [R11]
    (status_rd && !reg_write_i) |=> !wrchk_err) else $error("status read did not clear flag");

  // Integrity flag.
  a_integ_set: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // [R13]
    (integrity_en_i && integ_en_q && differs) |=> converter_status_o[BIT_INTEG]) else $error("integrity flag not set");
  a_integ_quiet: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // [R13]
    capture |=> !integ_err) else $error("integrity flag set by snapshot");
  a_integ_clear: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // [R14]
    !integrity_en_i |=> !converter_status_o[BIT_INTEG]) else $error("integrity flag not cleared");
  a_integ_sticky: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // [R14]
    (integ_err && integrity_en_i) |=> integ_err) else $error("integrity flag dropped");

  // Channel field and appended status byte.
  a_channel_copy: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // [R15]
    result_wr_i |=> converter_status_o[3:0] == $past(result_channel_i)) else $error("channel not copied");
  a_channel_hold: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // [R15]
    !result_wr_i |=> $stable(converter_status_o[3:0])) else $error("channel changed without result");
  a_append_byte: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // [R2]
    (data_rd && append_status_i) |=> append_byte_o) else $error("status not appended");
  a_append_quiet: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // [R2]
    !(data_rd && append_status_i) |=> !append_byte_o) else $error("status appended without data read");

  // Main scenarios.
  c_result: cover property (@(posedge ref_clk_i) disable iff (!rst_b_i) result_wr_i ##1 data_rd);
  c_crc: cover property (@(posedge ref_clk_i) disable iff (!rst_b_i) write_crc_fail_i && reg_write_i ##[1:4] status_rd);
  c_integ: cover property (@(posedge ref_clk_i) disable iff (!rst_b_i) integ_err ##1 !integrity_en_i);
  c_calib: cover property (@(posedge ref_clk_i) disable iff (!rst_b_i) calib_mode_i && calib_done_i);
  c_mode: cover property (@(posedge ref_clk_i) disable iff (!rst_b_i) mode_wr ##1 dout_ready_o);
endmodule : converter_status
`default_nettype wire

// ### conv_status_pkg.sv
// Purpose: Shared constants for the converter status register block.
// Assumes: Single clock domain at 125 MHz.
// Notes: Addresses are register selects carried in the communications byte.
package conv_status_pkg;
  localparam logic [5:0] STATUS_ADDR = 6'h00;
  localparam logic [5:0] MODE_ADDR = 6'h01;
  localparam logic [5:0] DATA_ADDR = 6'h04;
  localparam logic [7:0] STATUS_RESET = 8'h80;
  localparam int BIT_WAITING = 7;
  localparam int BIT_RANGE = 6;
  localparam int BIT_WRCHK = 5;
  localparam int BIT_INTEG = 4;
  localparam int DATA_W = 24;
  localparam logic [23:0] DATA_ALL_ONES = 24'hFFFFFF;
  localparam logic [23:0] DATA_ALL_ZEROS = 24'h000000;
  localparam int SNAP_W = 32;
endpackage : conv_status_pkg

// ### integrity_snapshot.sv
// Purpose: Holds the register image captured when the integrity check starts.
// Assumes: Image presented as one flat word.
// Notes: Compare result is registered.
`timescale 1ns/1ps
`default_nettype none
module integrity_snapshot
  import conv_status_pkg::*;
(
  // Clock and reset.
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  // Image and control.
  input wire logic capture_i,
  input wire logic [SNAP_W-1:0] image_i,
  output logic differs_o
);
  logic [SNAP_W-1:0] held;
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      held <= '0;
      differs_o <= 1'b0;
    end else begin
      if (capture_i) begin
        held <= image_i;
      end
      differs_o <= !capture_i && (held != image_i);
    end
  end
endmodule : integrity_snapshot
`default_nettype wire

// ### host_model.sv
// Purpose: Host side of the serial link, issuing decoded register accesses.
// Assumes: Accesses are launched just after a rising clock edge.
// Notes: A released select carries the inverse value so stale data is never read.
`timescale 1ns/1ps
`default_nettype none
module host_model (
  // Clock.
  input wire logic ref_clk_i,
  // Decoded serial access.
  output logic cs_b_o,
  output logic rd_o,
  output logic [5:0] sel_o,
  output logic wr_o,
  output logic crc_bad_o
);
  initial begin
    {cs_b_o, rd_o, sel_o, wr_o, crc_bad_o} = {1'b1, 1'b0, 6'h3F, 1'b0, 1'b0};
  end
  // The host checks read CRC itself, so no read carries a fault flag.
  task access(input logic r, input logic [5:0] s, input logic bad);
    {cs_b_o, rd_o, wr_o, sel_o, crc_bad_o} = {1'b0, r, !r, s, bad & !r};
    @(posedge ref_clk_i) #1;
    {rd_o, wr_o, sel_o, crc_bad_o} = {1'b0, 1'b0, ~s, 1'b0};
  endtask : access
endmodule : host_model
`default_nettype wire

// ### test_adc_status_register.sv
// Purpose: Self-checking bench for the converter status register.
// Assumes: Outputs settle one cycle after the causing edge.
// Notes: Chip select stays low once the host has spoken, so the ready pin is watched.
`timescale 1ns/1ps
`default_nettype none
module test_adc_status_register;
  import conv_status_pkg::*;
  logic ref_clk_i = 1'b0, rst_b_i = 1'b0, rw = 1'b0, cm = 1'b0, cd = 1'b0, ov = 1'b0, un = 1'b0;
  logic app = 1'b0, ien = 1'b0, cs_b, rd, wr, bad, apb, rdy, oe_b;
  logic [3:0] ch = 4'h0;
  logic [5:0] sel;
  logic [DATA_W-1:0] dat;
  logic [SNAP_W-1:0] img = 32'h0;
  logic [7:0] st;
  int errors = 0, n_compared = 0, cyc = 0;
  always #4 ref_clk_i = ~ref_clk_i;
  host_model host_u (.ref_clk_i, .cs_b_o(cs_b), .rd_o(rd), .sel_o(sel), .wr_o(wr), .crc_bad_o(bad));
  converter_status dut_u (.ref_clk_i, .rst_b_i, .result_wr_i(rw), .calib_mode_i(cm), .calib_done_i(cd),
    .raw_result_i(24'h123456), .over_range_i(ov), .under_range_i(un), .result_channel_i(ch), .cs_b_i(cs_b),
    .reg_read_i(rd), .comms_register_select_i(sel), .reg_write_i(wr), .write_crc_fail_i(bad),
    .append_status_i(app), .integrity_en_i(ien), .reg_image_i(img), .converter_status_o(st),
    .data_reg_o(dat), .append_byte_o(apb), .dout_ready_o(rdy), .dout_oe_b_o(oe_b));
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s: expected %0h seen %0h", what, exp, got);
    end
  endtask : chk
  task tick(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask : tick
  task result(input logic [3:0] c, input logic o, input logic u);
    {ch, ov, un, rw} = {c, o, u, 1'b1};
    tick(1);
    {ov, un, rw} = 3'h0;
  endtask : result
  task t_results;
    result(4'hF, 1'b1, 1'b0);
    chk("status", 8'h4F, st);
    chk("data", DATA_ALL_ONES, dat);
    result(4'h0, 1'b0, 1'b1);
    chk("data", DATA_ALL_ZEROS, dat);
    result(4'h3, 1'b0, 1'b0);
    chk("data", 24'h123456, dat);
    ov = 1'b1;
    tick(1);
    ov = 1'b0;
    chk("status", 8'h03, st);
  endtask : t_results
  task t_read_path;
    app = 1'b1;
    host_u.access(1'b1, DATA_ADDR, 1'b0);
    chk("append", 1'b1, apb);
    chk("status", 8'h83, st);
    chk("pin enable", 1'b1, oe_b);
    tick(1);
    chk("append", 1'b0, apb);
    chk("pin enable", 1'b0, oe_b);
    chk("ready pin", 1'b1, rdy);
    result(4'h5, 1'b0, 1'b0);
    chk("ready pin", 1'b0, rdy);
  endtask : t_read_path
  task t_crc_mode;
    host_u.access(1'b0, 6'h02, 1'b1);
    chk("write check", 1'b1, st[5]);
    // An edge passes between accesses so no strobe rises in the step where it fell.
    tick(1);
    host_u.access(1'b1, STATUS_ADDR, 1'b0);
    chk("write check", 1'b0, st[5]);
    tick(1);
    host_u.access(1'b0, MODE_ADDR, 1'b0);
    chk("waiting", 1'b1, st[7]);
  endtask : t_crc_mode
  task t_calib;
    cm = 1'b1;
    result(4'h2, 1'b0, 1'b0);
    chk("waiting", 1'b1, st[7]);
    cd = 1'b1;
    tick(1);
    cd = 1'b0;
    chk("waiting", 1'b0, st[7]);
    cm = 1'b0;
  endtask : t_calib
  task t_integrity;
    ien = 1'b1;
    tick(2);
    img = 32'hA5;
    tick(3);
    chk("integrity", 1'b1, st[4]);
    host_u.access(1'b1, STATUS_ADDR, 1'b0);
    chk("integrity", 1'b1, st[4]);
    ien = 1'b0;
    tick(2);
    chk("integrity", 1'b0, st[4]);
    // Re-arming must take a fresh snapshot instead of flagging the stale compare.
    ien = 1'b1;
    tick(3);
    chk("integrity", 1'b0, st[4]);
  endtask : t_integrity
  task report_and_stop;
    $display("compared %0d, errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : report_and_stop
  // The ceiling leaves ample room over the roughly 34 cycles the tasks need.
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 2000) begin
      errors++;
      report_and_stop();
    end
  end
  initial begin
    tick(8);
    rst_b_i = 1'b1;
    tick(1);
    chk("status", STATUS_RESET, st);
    t_results();
    t_read_path();
    t_crc_mode();
    t_calib();
    t_integrity();
    report_and_stop();
  end
endmodule : test_adc_status_register
`default_nettype wire
